// ---- cpfc_frame_cfg.v ----
/*
  Codec port frame configuration: serial clock and frame sync generation
  or sampling, frame sync length and polarity, sample byte order.
  Assumes configuration bits are static outputs of an MCU register and
  that samples arrive one per core cycle pulse from the DMA path.
*/
// Operation
// (R1) Length select 1: frame sync lasts as many serial clocks as slot 0.
// (R2) Length select 0: frame sync lasts exactly one serial clock.
// (R3) Byte swap 1: reverse byte order of every DMA-moved sample.
// (R4) Byte swap 0: samples pass with byte order unchanged.
// (R5) Mono I2S channels ignore byte swap; never reorder.
// (R6) Serial clock direction 1: pin is input; 0: device drives it.
// (R7) Frame sync direction 1: pin is input; 0: device generates and drives it.
// (R8) Polarity 1 makes generated frame sync active high, 0 active low.
// (R9) Input clock or sync is supplied continuously by the codec; timing follows it.
`timescale 1ns/1ps
`include "cpfc_map.vh"
module cpfc_frame_cfg (
  // Clock and reset
  input wire ref_clk_i,
  input wire nrst_i,
  // Configuration
  input wire frame_sync_length_sel_i,
  input wire sample_byte_swap_i,
  input wire serial_clock_dir_i,
  input wire frame_sync_dir_i,
  input wire frame_sync_polarity_i,
  input wire mono_i2s_i,
  input wire [`CPFC_SLOT_W-1:0] slot0_len_i,
  input wire [`CPFC_FRAME_W-1:0] frame_len_i,
  // Serial clock pin
  input wire serial_clock_i,
  output reg serial_clock_o,
  output wire serial_clock_oe_o,
  // Frame sync pin
  input wire frame_sync_i,
  output reg frame_sync_o,
  output wire frame_sync_oe_o,
  // Timing status
  output reg sclk_rise_o,
  output reg frame_start_o,
  // Sample path
  input wire sample_valid_i,
  input wire [`CPFC_SAMPLE_W-1:0] sample_i,
  output reg sample_valid_o,
  output reg [`CPFC_SAMPLE_W-1:0] sample_o
);
  localparam [`CPFC_DIV_W-1:0] HALF_CYC = `CPFC_DIV_LAST;

  reg [`CPFC_DIV_W-1:0] div_cnt;
  reg int_sclk;
  reg sclk_prev;
  reg fs_prev;
  reg [`CPFC_FRAME_W-1:0] bit_cnt;
  reg [`CPFC_SLOT_W-1:0] fs_cnt;
  reg fs_active;
  // Next-state values of the timing registers
  reg [`CPFC_DIV_W-1:0] next_div_cnt;
  reg next_int_sclk;
  reg [`CPFC_FRAME_W-1:0] next_bit_cnt;
  reg [`CPFC_SLOT_W-1:0] next_fs_cnt;
  reg next_fs_active;
  reg next_frame_start;
  wire frame_wrap;
  wire first_frame;
  wire ext_sclk;
  wire ext_fs;
  wire sclk_now;
  wire sclk_rise;
  wire ext_fs_start;
  wire [`CPFC_SLOT_W-1:0] fs_len;

  function [`CPFC_SAMPLE_W-1:0] swap_bytes;
    input [`CPFC_SAMPLE_W-1:0] d;
    begin
      swap_bytes = {d[7:0], d[15:8]};
    end
  endfunction

  // Frame bit counter step, shared by both sync directions
  function [`CPFC_FRAME_W-1:0] frame_inc;
    input [`CPFC_FRAME_W-1:0] c;
    begin
      frame_inc = c + 8'h01;
    end
  endfunction

  // Pin level of the generated sync for the selected polarity
  function sync_level;
    input active;
    input polarity;
    begin
      sync_level = polarity ? active : ~active;
    end
  endfunction

  // Pin inputs pass four flops (three stages plus filter) before any edge is looked for
  cpfc_sync3 u_sclk_sync (
    .clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .d_i(serial_clock_i),
    .q_o(ext_sclk)
  );

  cpfc_sync3 u_fs_sync (
    .clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .d_i(frame_sync_i),
    .q_o(ext_fs)
  );

  assign serial_clock_oe_o = ~serial_clock_dir_i; // R6
  assign frame_sync_oe_o = ~frame_sync_dir_i; // R7
  // External clock replaces internal generation
  assign sclk_now = serial_clock_dir_i ? ext_sclk : int_sclk; // R9
  assign sclk_rise = sclk_now & ~sclk_prev;
  // External sync seen active per programmed polarity
  assign ext_fs_start = frame_sync_dir_i & sclk_rise &
    ((ext_fs == frame_sync_polarity_i) & (fs_prev != frame_sync_polarity_i)); // R9
  // Zero slot length would give no pulse; hold at least one clock
  assign fs_len = frame_sync_length_sel_i ?
    ((slot0_len_i == 5'h00) ? 5'h01 : slot0_len_i) : 5'h01; // R1 R2
  // Generated frame ends at the programmed length
  assign frame_wrap = bit_cnt == frame_len_i;
  // First rise after reset opens a frame at once
  assign first_frame = !fs_active && bit_cnt == 8'h00 && fs_cnt == 5'h00;

  // Divider runs even while the pin is an input, so a direction change needs no restart
  always @* begin
    next_div_cnt = div_cnt + 4'h1;
    next_int_sclk = int_sclk;
    if (div_cnt == HALF_CYC) begin
      next_div_cnt = {`CPFC_DIV_W{1'b0}};
      next_int_sclk = ~int_sclk;
    end
  end

  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_cnt <= {`CPFC_DIV_W{1'b0}};
      int_sclk <= 1'b0;
      serial_clock_o <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      int_sclk <= next_int_sclk;
      serial_clock_o <= int_sclk; // R6
    end
  end

  // Frame timing next state
  always @* begin
    next_bit_cnt = bit_cnt;
    next_fs_cnt = fs_cnt;
    next_fs_active = fs_active;
    next_frame_start = 1'b0;
    if (frame_sync_dir_i) begin
      // External sync: no pulse of our own, counter realigns on each start
      next_fs_active = 1'b0;
      next_fs_cnt = {`CPFC_SLOT_W{1'b0}};
      if (ext_fs_start) begin
        next_bit_cnt = {`CPFC_FRAME_W{1'b0}}; // R9
        next_frame_start = 1'b1;
      end else if (sclk_rise) begin
        next_bit_cnt = frame_inc(bit_cnt);
      end
    end else if (sclk_rise) begin
      next_bit_cnt = frame_wrap ? {`CPFC_FRAME_W{1'b0}} : frame_inc(bit_cnt);
      if (frame_wrap || first_frame) begin
        next_fs_active = 1'b1;
        next_fs_cnt = fs_len - 5'h01;
        next_frame_start = 1'b1;
      end else if (fs_cnt != 5'h00) begin
        next_fs_cnt = fs_cnt - 5'h01; // R1
      end else begin
        next_fs_active = 1'b0; // R2
      end
    end
  end

  // Pin follows fs_active one core cycle later
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sclk_prev <= 1'b0;
      fs_prev <= 1'b0;
      bit_cnt <= {`CPFC_FRAME_W{1'b0}};
      fs_cnt <= {`CPFC_SLOT_W{1'b0}};
      fs_active <= 1'b0;
      frame_sync_o <= 1'b0;
      sclk_rise_o <= 1'b0;
      frame_start_o <= 1'b0;
    end else begin
      sclk_prev <= sclk_now;
      sclk_rise_o <= sclk_rise;
      if (sclk_rise) begin
        fs_prev <= ext_fs;
      end
      bit_cnt <= next_bit_cnt;
      fs_cnt <= next_fs_cnt;
      fs_active <= next_fs_active;
      frame_start_o <= next_frame_start;
      frame_sync_o <= sync_level(fs_active, frame_sync_polarity_i); // R8
    end
  end

  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sample_valid_o <= 1'b0;
      sample_o <= {`CPFC_SAMPLE_W{1'b0}};
    end else begin
      sample_valid_o <= sample_valid_i;
      // Data holds between valid pulses
      if (sample_valid_i) begin
        if (sample_byte_swap_i && !mono_i2s_i) begin
          sample_o <= swap_bytes(sample_i); // R3
        end else begin
          sample_o <= sample_i; // R4 R5
        end
      end
    end
  end
endmodule

// ---- cpfc_map.vh ----
/*
  Constants of the codec port frame configuration block: field widths,
  reset values and serial clock divider counts.
  Assumes a 10 MHz core clock; included by the design files only.
*/
`ifndef CPFC_MAP_VH
`define CPFC_MAP_VH

// Core clock period in ns
`define CPFC_CLK_PERIOD_NS 100
// Generated serial clock half period in ns
`define CPFC_SCLK_HALF_NS 400
// Half period in core cycles, rounded down, at least one
`define CPFC_SCLK_HALF_CYC ((`CPFC_SCLK_HALF_NS / `CPFC_CLK_PERIOD_NS) < 1 ? 1 : \
  (`CPFC_SCLK_HALF_NS / `CPFC_CLK_PERIOD_NS))
// Last divider count of a half period (four core cycles)
`define CPFC_DIV_LAST 4'h3
`define CPFC_DIV_W 4
`define CPFC_SAMPLE_W 16
`define CPFC_SLOT_W 5
// Default time slot 0 length in serial clocks
`define CPFC_SLOT0_LEN_RST 5'h10
// Serial clocks per frame, minus one
`define CPFC_FRAME_LEN_RST 8'h3f
`define CPFC_FRAME_W 8

`endif

// ---- cpfc_sync3.v ----
/*
  Three-stage input synchroniser with agreement filter.
  Assumes the input is asynchronous to clk_i; output changes once
  stages two and three agree.
*/
`timescale 1ns/1ps
module cpfc_sync3 (
  // Clock and reset
  input wire clk_i,
  input wire nrst_i,
  // Data
  input wire d_i,
  output reg q_o
);
  reg s1;
  reg s2;
  reg s3;

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      q_o <= 1'b0;
    end else begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        q_o <= s3;
      end
    end
  end
endmodule

// ---- cpfc_codec_model.sv ----
/* Codec on the serial side: free serial clock, one-clock sync per 32.
   Assumes the bench resolves pins from the enables. */
`timescale 1ns/1ps
module cpfc_codec_model (
  // Serial pins
  output reg sclk_o,
  output reg fs_o
);
  integer k = 0;
  initial sclk_o = 0;
  initial fs_o = 0;
  // Runs free all run; the bench uses it only when the DUT pins are inputs
  always #400 sclk_o = !sclk_o;
  always @(negedge sclk_o) begin
    k = (k + 1) % 32;
    fs_o <= k == 0;
  end
endmodule

// ---- cpfc_frame_cfg_props.sv ----
/* Port checker for cpfc_frame_cfg.
   Assumes an eight core cycle serial clock. */
`timescale 1ns/1ps
module cpfc_frame_cfg_props (
  // Clock, reset
  input wire ref_clk_i,
  input wire nrst_i,
  // Configuration
  input wire frame_sync_length_sel_i,
  input wire sample_byte_swap_i,
  input wire serial_clock_dir_i,
  input wire frame_sync_dir_i,
  input wire frame_sync_polarity_i,
  input wire mono_i2s_i,
  input wire [4:0] slot0_len_i,
  // Pins, samples
  input wire serial_clock_o,
  input wire serial_clock_oe_o,
  input wire frame_sync_o,
  input wire frame_sync_oe_o,
  input wire sclk_rise_o,
  input wire frame_start_o,
  input wire sample_valid_i,
  input wire [15:0] sample_i,
  input wire [15:0] sample_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  wire act = frame_sync_o == frame_sync_polarity_i;
  wire gen = !frame_sync_dir_i && !serial_clock_dir_i;
  reg [8:0] n;
  // Count only real pulses, not the idle level after reset
  always @(posedge ref_clk_i or negedge nrst_i)
    if (!nrst_i) n <= 9'h0;
    else n <= frame_start_o ? 9'h1 : (act && n != 9'h0) ? n + 9'h1 : 9'h0;
  a_oe_clock: assert property (serial_clock_oe_o == !serial_clock_dir_i) else $error("oe");
  a_oe_sync: assert property (frame_sync_oe_o == !frame_sync_dir_i) else $error("oe");
  a_swap_on: assert property (sample_valid_i && sample_byte_swap_i && !mono_i2s_i |=>
    sample_o == {$past(sample_i[7:0]), $past(sample_i[15:8])}) else $error("swap");
  a_swap_off: assert property (sample_valid_i && !sample_byte_swap_i |=>
    sample_o == $past(sample_i)) else $error("order");
  a_mono_pass: assert property (sample_valid_i && mono_i2s_i |=> sample_o == $past(sample_i))
    else $error("mono");
  a_sync_one: assert property ($rose(act) && gen && !frame_sync_length_sel_i |-> act[*8] ##1 !act)
    else $error("short");
  // Count includes the frame start cycle; slot length 0 not covered here
  a_sync_slot: assert property ($fell(act) && gen && frame_sync_length_sel_i && n != 9'h0 |->
    n == {1'b0, slot0_len_i, 3'h0} + 9'h1) else $error("long");
  // Pin goes active the cycle after the start pulse
  a_sync_polar: assert property (frame_start_o && !frame_sync_dir_i |=> act) else $error("pol");
  a_rise_pulse: assert property (!serial_clock_dir_i |-> sclk_rise_o == $rose(serial_clock_o))
    else $error("rise");
  c_long: cover property ($fell(act) && frame_sync_length_sel_i);
  c_ext: cover property (frame_start_o && frame_sync_dir_i);
  c_mono: cover property (sample_valid_i && mono_i2s_i);
endmodule
bind cpfc_frame_cfg cpfc_frame_cfg_props chk (
  .ref_clk_i(ref_clk_i),
  .nrst_i(nrst_i),
  .frame_sync_length_sel_i(frame_sync_length_sel_i),
  .sample_byte_swap_i(sample_byte_swap_i),
  .serial_clock_dir_i(serial_clock_dir_i),
  .frame_sync_dir_i(frame_sync_dir_i),
  .frame_sync_polarity_i(frame_sync_polarity_i),
  .mono_i2s_i(mono_i2s_i),
  .slot0_len_i(slot0_len_i),
  .serial_clock_o(serial_clock_o),
  .serial_clock_oe_o(serial_clock_oe_o),
  .frame_sync_o(frame_sync_o),
  .frame_sync_oe_o(frame_sync_oe_o),
  .sclk_rise_o(sclk_rise_o),
  .frame_start_o(frame_start_o),
  .sample_valid_i(sample_valid_i),
  .sample_i(sample_i),
  .sample_o(sample_o)
);

// ---- cpfc_frame_cfg_tb.sv ----
/* Bench for cpfc_frame_cfg: sync timing and sample order.
   Assumes the codec model and bound checker. */
`timescale 1ns/1ps
module cpfc_frame_cfg_tb;
  reg clk = 0, nrst = 0, ls = 0, sw = 0, sd = 0, fd = 0, pol = 0, mo = 0, vld = 0;
  reg [15:0] d = 16'h0;
  wire sco, sce, fso, fse, mck, mfs, fst, vo;
  wire [15:0] q;
  integer miscompares = 0, checked = 0, i, n;
  reg ck;
  cpfc_codec_model codec (.sclk_o(mck), .fs_o(mfs));
  cpfc_frame_cfg DUT (.ref_clk_i(clk), .nrst_i(nrst), .frame_sync_length_sel_i(ls), .sample_byte_swap_i(sw),
    .serial_clock_dir_i(sd), .frame_sync_dir_i(fd), .frame_sync_polarity_i(pol), .mono_i2s_i(mo),
    .slot0_len_i(5'h03), .frame_len_i(8'h0f), .serial_clock_i(sce ? sco : mck), .serial_clock_o(sco),
    .serial_clock_oe_o(sce), .frame_sync_i(fse ? fso : mfs), .frame_sync_o(fso), .frame_sync_oe_o(fse),
    .sclk_rise_o(), .frame_start_o(fst), .sample_valid_i(vld), .sample_i(d), .sample_valid_o(vo), .sample_o(q));
  initial forever #50 clk = !clk;
  task chk(input [79:0] nm, input [15:0] e, g);
    begin
      checked = checked + 1;
      if (e !== g) begin
        miscompares = miscompares + 1;
        $display("BAD %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task rst(input l, p, s, f);
    begin
      nrst = 0; ls = l; pol = p; sd = s; fd = f;
      repeat (4) @(negedge clk);
      nrst = 1;
      chk("sclk_oe", !s, sce);
      chk("sync_oe", !f, fse);
      n = 0;
      while (fst !== 1'b1 && n < 700) begin
        n = n + 1;
        @(negedge clk);
      end
      chk("start", 1, fst);
    end
  endtask
  // Valid stays up between calls, so samples go back to back
  task smp(input [15:0] v, input s, m, input [15:0] e);
    begin
      d = v; sw = s; mo = m; vld = 1;
      @(negedge clk);
      chk("valid", 1, vo);
      chk("sample", e, q);
    end
  endtask
  task finish_test;
    begin
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    #500000;
    miscompares = miscompares + 1;
    finish_test;
  end
  initial begin
    for (i = 0; i < 4; i = i + 1) begin
      rst(i[0], i[1], 1'b0, 1'b0);
      // Pin lags the frame start pulse by one core cycle
      @(negedge clk);
      n = 0;
      while (fso === pol && n < 300) begin
        n = n + 1;
        @(negedge clk);
      end
      chk("sync_len", ls ? 16'h18 : 16'h8, n[15:0]);
      // Serial clock pin toggles every four core cycles
      ck = sco;
      n = 0;
      while (sco === ck && n < 20) begin
        n = n + 1;
        @(negedge clk);
      end
      ck = sco;
      n = 0;
      while (sco === ck && n < 20) begin
        n = n + 1;
        @(negedge clk);
      end
      chk("sclk_half", 16'h4, n[15:0]);
    end
    rst(1'b0, 1'b1, 1'b1, 1'b1);
    smp(16'h1234, 1'b1, 1'b0, 16'h3412);
    smp(16'h00ff, 1'b1, 1'b0, 16'hff00);
    smp(16'h1234, 1'b0, 1'b0, 16'h1234);
    smp(16'habcd, 1'b1, 1'b1, 16'habcd);
    vld = 0;
    finish_test;
  end
endmodule
